// *** core/pif_flag.sv ***
`timescale 1ns/10ps
`include "pif_params.svh"
// One persistent flag: set by condition, cleared only when condition is gone
module pif_flag
   import pif_pkg::*;
(
   input wire logic clk_i,     // System clock
   input wire logic reset_i,   // Async reset, high
   input wire logic cond_i,    // Source condition level
   input wire logic clear_i,   // Software clear pulse
   output logic flag_o         // Pending flag
);
   pif_state_t state; // Flag state
   // Set wins over clear; clear ignored while condition holds
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= PIF_IDLE;
      end else begin
         case (state)
            PIF_IDLE: if (cond_i) state <= PIF_PEND;
            PIF_PEND: if (clear_i && !cond_i) state <= PIF_IDLE;
            default: state <= PIF_IDLE;
         endcase
      end
   end
   assign flag_o = (state == PIF_PEND);
   a_flag_holds: assert property (@(posedge clk_i) disable iff (reset_i)
      cond_i |=> flag_o) else $error("flag lost while condition active");
   a_clear_works: assert property (@(posedge clk_i) disable iff (reset_i)
      flag_o && clear_i && !cond_i |=> !flag_o) else $error("clear ignored");
endmodule // pif_flag

// *** core/pif_params.svh ***
`ifndef PIF_PARAMS_SVH
`define PIF_PARAMS_SVH
// Select field and count widths
`define PIF_SEL_W 2
`define PIF_CNT_W 3
// Interrupt request numbers of the synchronous serial interface
`define PIF_IRQ_SYNC_RX 8'h18
`define PIF_IRQ_SYNC_TX 8'h19
// Depth of each buffered source
`define PIF_DEPTH 3'h4
// Reset value of every flag
`define PIF_FLAG_RST 1'h0
`endif

// *** core/pif_pkg.sv ***
package pif_pkg;
   // Clear handling state of one flag
   typedef enum logic [1:0] {
      PIF_IDLE = 2'h1,
      PIF_PEND = 2'h2
   } pif_state_t;
endpackage

// *** core/pif_top.sv ***
// Summary of operation
// - Flag stays set while condition active
// - Serial receive clear needs holding register read
// - Sync serial rx irq 24, tx irq 25
// - Capture holds until count at or below threshold
// - Sync serial rx/tx use separate selects
// - Async transmit irq raised upon enable
// - Async rx/tx conditions from select fields
// - Converter holds until all samples read
// - Parallel port holds until data read
`timescale 1ns/10ps
`include "pif_params.svh"
module pif_top
   import pif_pkg::*;
(
   input wire logic clk_i,                             // System clock
   input wire logic reset_i,                           // Async reset, high
   input wire logic capture_push_i,                    // Capture result stored
   input wire logic capture_result_buffer_rd_i,        // Capture buffer read
   input wire logic [1:0] capture_irq_threshold_i,     // Capture threshold field
   input wire logic sync_rx_push_i,                    // Sync serial word received
   input wire logic sync_tx_pop_i,                     // Sync serial word sent
   input wire logic sync_serial_data_buffer_rd_i,      // Sync buffer read
   input wire logic sync_serial_data_buffer_wr_i,      // Sync buffer write
   input wire logic [1:0] sync_rx_irq_select_i,        // Sync receive level
   input wire logic [1:0] sync_tx_irq_select_i,        // Sync transmit level
   input wire logic async_enable_i,                    // Async port enabled
   input wire logic async_rx_push_i,                   // Async byte received
   input wire logic async_tx_pop_i,                    // Async byte sent
   input wire logic async_rx_holding_rd_i,             // Async receive read
   input wire logic async_tx_holding_wr_i,             // Async transmit write
   input wire logic [1:0] async_rx_irq_select_i,       // Async receive level
   input wire logic [1:0] async_tx_irq_select_i,       // Async transmit level
   input wire logic converter_sample_i,                // Conversion sample stored
   input wire logic converter_result_slots_rd_i,       // Result slot read
   input wire logic parallel_master_port_done_i,       // Parallel cycle done
   input wire logic parallel_port_data_reg_rd_i,       // Parallel data read
   input wire logic [6:0] clear_i,                     // Software clear per flag
   output logic [6:0] flag_o,                          // Pending flags
   output logic serial_port_irq_flag_o,                // Async receive flag copy
   output logic [7:0] sync_rx_irq_num_o,               // Sync receive irq number
   output logic [7:0] sync_tx_irq_num_o                // Sync transmit irq number
);
   // Saturating counter step: up on push, down on pop
   function automatic logic [`PIF_CNT_W-1:0] step(input logic [`PIF_CNT_W-1:0] c,
                                                    input logic up, input logic dn);
      logic [`PIF_CNT_W-1:0] r;
      r = c;
      if (up && !dn && c != `PIF_DEPTH) r = c + 3'h1;
      else if (dn && !up && c != 3'h0) r = c - 3'h1;
      return r;
   endfunction
   // Level check: condition when count reaches select+1
   function automatic logic at_level(input logic [`PIF_CNT_W-1:0] c,
                                     input logic [1:0] sel);
      return c > {1'h0, sel};
   endfunction

   // Free-space check: transmit condition while free slots exceed the select
   function automatic logic free_level(input logic [`PIF_CNT_W-1:0] c,
                                       input logic [1:0] sel);
      return (`PIF_DEPTH - c) > {1'h0, sel};
   endfunction

   // Fill levels and conditions
   logic [`PIF_CNT_W-1:0] cap_cnt;  // Stored capture results
   logic [`PIF_CNT_W-1:0] srx_cnt;  // Sync pending receive
   logic [`PIF_CNT_W-1:0] stx_cnt;  // Sync pending transmit
   logic [`PIF_CNT_W-1:0] arx_cnt;  // Async pending receive
   logic [`PIF_CNT_W-1:0] atx_cnt;  // Async pending transmit
   logic [`PIF_CNT_W-1:0] adc_cnt;  // Stored conversion samples
   logic pmp_cond;                  // Parallel data unread
   logic [6:0] cond;                // Conditions
   logic [6:0] flag;                // Flag states

   // Capture fill level; each buffer read removes one stored result
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         // Buffer empty after reset
         cap_cnt <= 3'h0;
      end else begin
         // Count results against reads
         cap_cnt <= step(cap_cnt, capture_push_i, capture_result_buffer_rd_i);
      end
   end

   // Sync serial fill levels; rx drained by reads, tx filled by writes
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         // Both directions empty after reset
         srx_cnt <= 3'h0;
         stx_cnt <= 3'h0;
      end else begin
         // Line traffic against buffer accesses
         srx_cnt <= step(srx_cnt, sync_rx_push_i, sync_serial_data_buffer_rd_i);
         stx_cnt <= step(stx_cnt, sync_serial_data_buffer_wr_i, sync_tx_pop_i);
      end
   end

   // Async fill levels; disabled port holds empty buffers, so enabling it
   // finds an empty transmit side and raises that flag at once
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         // Both buffers empty after reset
         arx_cnt <= 3'h0;
         atx_cnt <= 3'h0;
      end else if (!async_enable_i) begin
         // Port off: buffers flushed
         arx_cnt <= 3'h0;
         atx_cnt <= 3'h0;
      end else begin
         // Port on: count traffic and register accesses
         arx_cnt <= step(arx_cnt, async_rx_push_i, async_rx_holding_rd_i);
         atx_cnt <= step(atx_cnt, async_tx_holding_wr_i, async_tx_pop_i);
      end
   end

   // Converter samples; the source stays until every stored slot is read
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         // No samples after reset
         adc_cnt <= 3'h0;
      end else begin
         // Samples in, slot reads out
         adc_cnt <= step(adc_cnt, converter_sample_i, converter_result_slots_rd_i);
      end
   end

   // Parallel data unread; a new completion wins over a read in the same cycle
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         // Nothing to read after reset
         pmp_cond <= 1'h0;
      end else if (parallel_master_port_done_i) begin
         // Cycle done: data waits in the register
         pmp_cond <= 1'h1;
      end else if (parallel_port_data_reg_rd_i) begin
         // Software read removes the source
         pmp_cond <= 1'h0;
      end
   end

   // Conditions; transmit ones count free space against the select level
   always_comb begin
      cond[0] = at_level(cap_cnt, capture_irq_threshold_i);
      cond[1] = at_level(srx_cnt, sync_rx_irq_select_i);
      cond[2] = free_level(stx_cnt, sync_tx_irq_select_i);
      cond[3] = at_level(arx_cnt, async_rx_irq_select_i);
      cond[4] = async_enable_i && free_level(atx_cnt, async_tx_irq_select_i);
      cond[5] = adc_cnt != 3'h0;
      cond[6] = pmp_cond;
   end

   // One persistent flag per source; once pending, each looks at its condition again only on a clear
   for (genvar i = 0; i < 7; i++) begin : g_flag
      pif_flag u_flag (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .cond_i(cond[i]),
         .clear_i(clear_i[i]),
         .flag_o(flag[i])
      );
   end

   // Registered outputs; nothing reaches a pin straight from logic
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         // All outputs low during reset
         flag_o <= 7'h00;
         serial_port_irq_flag_o <= `PIF_FLAG_RST;
         sync_rx_irq_num_o <= 8'h00;
         sync_tx_irq_num_o <= 8'h00;
      end else begin
         // Flags one cycle behind their state
         flag_o <= flag;
         serial_port_irq_flag_o <= flag[3];
         sync_rx_irq_num_o <= `PIF_IRQ_SYNC_RX;
         sync_tx_irq_num_o <= `PIF_IRQ_SYNC_TX;
      end
   end

   // Enabling the async port raises its transmit flag two edges later
   a_tx_on_enable: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(async_enable_i) && atx_cnt == 3'h0 |=> ##1 flag_o[4])
      else $error("transmit flag not raised on enable");

   // Converter flag stays pending while any sample is unread
   a_adc_all_read: assert property (@(posedge clk_i) disable iff (reset_i)
      adc_cnt != 3'h0 |=> flag[5])
      else $error("converter flag dropped with samples unread");

   // Parallel source stays until its data register is read
   a_pmp_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      pmp_cond && !parallel_port_data_reg_rd_i |=> pmp_cond)
      else $error("parallel condition lost");

   // A clear of the async receive flag with the count above its level is refused
   a_rx_clear_refused: assert property (@(posedge clk_i) disable iff (reset_i)
      flag[3] && cond[3] && clear_i[3] |=> ##1 serial_port_irq_flag_o)
      else $error("receive clear not refused");

   // Irq numbers stand from the second edge after reset
   a_irq_numbers: assert property (@(posedge clk_i) disable iff (reset_i)
      !$past(reset_i) |-> sync_rx_irq_num_o == 8'h18 && sync_tx_irq_num_o == 8'h19)
      else $error("irq numbers wrong");

   // Capture flag only clears once the count is at or below its level
   a_cap_level: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(flag[0]) |-> $past(cap_cnt) <= {1'h0, $past(capture_irq_threshold_i)})
      else $error("capture flag cleared above level");

   // Sync receive flag only clears once the pending count is at or below its level
   a_srx_level: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(flag[1]) |-> $past(srx_cnt) <= {1'h0, $past(sync_rx_irq_select_i)})
      else $error("sync receive flag cleared above level");

   // Async transmit flag only clears once free space is at or below its level, or the port is off
   a_atx_level: assert property (@(posedge clk_i) disable iff (reset_i)
      $fell(flag[4]) |-> !$past(async_enable_i) ||
      (`PIF_DEPTH - $past(atx_cnt)) <= {1'h0, $past(async_tx_irq_select_i)})
      else $error("async transmit flag cleared above level");

   // Main scenarios: service, parallel read, full converter, enable, refusal
   c_rx_service: cover property (@(posedge clk_i) flag[3] ##[1:8] !flag[3]);
   c_pmp_done: cover property (@(posedge clk_i) pmp_cond ##1 !pmp_cond);
   c_adc_full: cover property (@(posedge clk_i) adc_cnt == `PIF_DEPTH);
   c_tx_enable: cover property (@(posedge clk_i) $rose(async_enable_i) ##2 flag_o[4]);
   c_clear_refused: cover property (@(posedge clk_i) flag[3] && cond[3] && clear_i[3]);
endmodule // pif_top

// *** tb/pif_isr.sv ***
`timescale 1ns/10ps
// Service routine model for the parallel port: read data first, then clear
module pif_isr (
   input wire logic clk_i,  // System clock
   input wire logic flag_i, // Parallel flag seen by core
   output logic rd_o,       // Data register read
   output logic clr_o       // Flag clear
);
   logic clr_d; // Clear of the cycle before
   // Idle until the first flag
   initial begin
      rd_o = 1'b0;
      clr_o = 1'b0;
      clr_d = 1'b0;
   end
   // Clearing before the read would be refused, so read comes first; hold off
   // two edges after a clear while the registered flag still shows its old value
   always @(posedge clk_i) begin
      rd_o <= flag_i && !rd_o && !clr_o && !clr_d;
      clr_o <= rd_o;
      clr_d <= clr_o;
   end
endmodule // pif_isr

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
   logic clk_i = 1'b0;   // System clock
   logic reset_i = 1'b1; // Reset, high
   logic [12:0] p = '0;  // Pulse inputs
   logic [5:0] clr = '0; // Clears of flags 0 to 5
   logic [1:0] sel = '0; // Shared level selects
   logic en = 1'b0;      // Async enable
   logic prd, pclr;      // Partner read and clear
   logic [6:0] flag_o;   // Flags
   logic spf;            // Async receive flag copy
   logic [7:0] nrx, ntx; // Irq numbers
   int failures = 0;     // Mismatches
   int compares = 0;     // Comparisons
   initial forever #5 clk_i = ~clk_i;
   pif_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .capture_push_i(p[0]),
      .capture_result_buffer_rd_i(p[1]), .capture_irq_threshold_i(sel),
      .sync_rx_push_i(p[2]), .sync_tx_pop_i(p[3]), .sync_serial_data_buffer_rd_i(p[4]),
      .sync_serial_data_buffer_wr_i(p[5]), .sync_rx_irq_select_i(sel),
      .sync_tx_irq_select_i(sel), .async_enable_i(en), .async_rx_push_i(p[6]),
      .async_tx_pop_i(p[7]), .async_rx_holding_rd_i(p[8]), .async_tx_holding_wr_i(p[9]),
      .async_rx_irq_select_i(sel), .async_tx_irq_select_i(sel),
      .converter_sample_i(p[10]), .converter_result_slots_rd_i(p[11]),
      .parallel_master_port_done_i(p[12]), .parallel_port_data_reg_rd_i(prd),
      .clear_i({pclr, clr}), .flag_o(flag_o), .serial_port_irq_flag_o(spf),
      .sync_rx_irq_num_o(nrx), .sync_tx_irq_num_o(ntx));
   pif_isr i_isr (.clk_i(clk_i), .flag_i(flag_o[6]), .rd_o(prd), .clr_o(pclr));
   // Compare and count
   task chk(string n, logic [7:0] v, logic [7:0] e);
      compares++;
      if (v !== e) begin
         failures++;
         $display("unexpected %s exp %h got %h", n, e, v);
      end
   endtask
   // One pulse, then let the two-stage flag pipeline settle
   task act(logic [12:0] m, logic [5:0] c);
      @(posedge clk_i);
      p <= m;
      clr <= c;
      @(posedge clk_i);
      p <= '0;
      clr <= '0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   // Transmit side: empty buffer meets the condition
   task t_tx;
      chk("rx irq num", nrx, 8'h18);
      chk("tx irq num", ntx, 8'h19);
      repeat (4) act(13'h0020, '0);
      act('0, 6'h04);
      chk("sync tx cleared", flag_o[2], 1'b0);
      act(13'h0008, '0);
      chk("sync tx rearmed", flag_o[2], 1'b1);
      @(posedge clk_i);
      en <= 1'b1;
      act('0, 6'h10);
      chk("async tx on enable", flag_o[4], 1'b1);
      repeat (4) act(13'h0200, '0);
      act('0, 6'h10);
      chk("async tx cleared", flag_o[4], 1'b0);
      act(13'h0080, '0);
      chk("async tx rearmed", flag_o[4], 1'b1);
   endtask
   // Receive side: every level, exactly at and above the boundary
   task t_level(int pu, int rd, int b, string n);
      for (int t = 0; t < 4; t++) begin
         @(posedge clk_i);
         sel <= t[1:0];
         repeat (t) act(13'h1 << pu, '0);
         chk(n, flag_o[b], 1'b0);
         act(13'h1 << pu, 6'h1 << b);
         chk(n, flag_o[b], 1'b1);
         act('0, 6'h1 << b);
         chk(n, flag_o[b], 1'b1);
         if (b == 3) chk("rx copy held", spf, 1'b1);
         act(13'h1 << rd, '0);
         act('0, 6'h1 << b);
         chk(n, flag_o[b], 1'b0);
         repeat (t) act(13'h1 << rd, '0);
      end
   endtask
   // Converter holds until the last sample is read
   task t_conv;
      repeat (4) act(13'h0400, '0);
      repeat (3) act(13'h0800, '0);
      act('0, 6'h20);
      chk("converter held", flag_o[5], 1'b1);
      act(13'h0800, 6'h00);
      act('0, 6'h20);
      chk("converter cleared", flag_o[5], 1'b0);
   endtask
   // Parallel port serviced by the partner
   task t_par;
      act(13'h1000, '0);
      chk("parallel raised", flag_o[6], 1'b1);
      for (int i = 0; i < 20 && flag_o[6] !== 1'b0; i++) begin
         @(posedge clk_i);
         #1;
      end
      chk("parallel serviced", flag_o[6], 1'b0);
   endtask
   // Verdict
   task finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      act('0, '0);
      t_tx;
      t_level(0, 1, 0, "capture flag");
      t_level(2, 4, 1, "sync rx flag");
      t_level(6, 8, 3, "async rx flag");
      t_conv;
      t_par;
      finish_test;
   end
endmodule // testbench
